// *** logic/amto_pkg.sv ***
// Package: register map, field layout and reset values of the offset bank
package amto_pkg;
    // Printed offsets are not multiples of four: these are word indices
    localparam logic [7:0] IDX_TEMP = 8'h06;
    localparam logic [7:0] IDX_MASK = 8'h07;
    localparam logic [7:0] IDX_OFFA = 8'h08;
    localparam logic [7:0] IDX_OFFB = 8'h09;
    // Own register holding the auto-sync enable
    localparam logic [7:0] IDX_SYNC = 8'h1E;
    localparam int ADDR_W = 10;
    localparam int TEMP_LSB = 8;
    localparam int OFF_W = 13;
    localparam int SYNC_AUTO_BIT = 0;
    localparam logic [15:0] MASK_RST = 16'hFFFF;
    localparam logic [15:0] MASK_USED = 16'hBFBE;
    localparam logic [15:0] OFFA_RST = 16'h0000;
    localparam logic [15:0] OFFB_RST = 16'h0000;
    localparam logic [2:0] FIFO_OFS_RST = 3'h4;
    localparam logic [15:0] SYNC_RST = 16'h0000;
endpackage

// *** logic/amto_regs.sv ***
// Alarm mask, die temperature readout and A/B offset correction registers
// Contract
// - The upper byte of the readout register is the sensor's two's-complement temperature in whole degrees C.
// - The readout register is read-only, its temperature has no reset value and its low bits read zero.
// - A 16-bit suppression register masks an alarm with a one and leaves it active with a zero.
// - The suppression register resets to all ones.
// - Mask bits map 15 zero-pointer, 13 collision, 12 one-away, 11 two-away, 10/9 clocks lost, 8 output forced, 7 pattern, 5 PLL, 4-1 parity A-D; 14, 6, 0 unused.
// - The channel-A offset register holds a 13-bit offset in its low bits with reserved upper bits at zero.
// - With auto-sync enabled, any write to the channel-A offset register raises a sync event.
// - A sync loads both the A and B offsets into the datapath in the same cycle.
// - A channel-B write alone only changes the staged value, not the applied offset.
// - The channel-A offset register resets to zero.
// - The channel-B staged offset is a 13-bit field of the neighbouring register.
`timescale 1ns/1ns
module amto_regs
    import amto_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Temperature sensor, alarm status (asynchronous sources)
    input wire logic [7:0] TEMP_SENSOR_I,
    input wire logic [15:0] ALARM_STATUS_I,
    // Offset datapath and combined alarm
    output logic [OFF_W-1:0] OFFSET_A_O,
    output logic [OFF_W-1:0] OFFSET_B_O,
    output logic OFFSET_SYNC_O,
    output logic ALARM_O
);

    logic [15:0] mask_reg;
    logic [OFF_W-1:0] offa_reg;
    logic [OFF_W-1:0] offb_reg;
    logic [2:0] fifo_ofs_reg;
    logic auto_sync_reg;
    logic [OFF_W-1:0] act_a_reg;
    logic [OFF_W-1:0] act_b_reg;
    logic sync_reg;
    logic [7:0] temp_s1_reg;
    logic [7:0] temp_s2_reg;
    logic [15:0] alarm_s1_reg;
    logic [15:0] alarm_s2_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Address decode; only whole aligned words are mapped
    wire logic access = PSEL_I && PENABLE_I;
    wire logic aligned = (PADDR_I[1:0] == 2'h0);
    wire logic [7:0] idx = PADDR_I[ADDR_W-1:2];
    wire logic hit_temp = aligned && (idx == IDX_TEMP);
    wire logic hit_mask = aligned && (idx == IDX_MASK);
    wire logic hit_offa = aligned && (idx == IDX_OFFA);
    wire logic hit_offb = aligned && (idx == IDX_OFFB);
    wire logic hit_sync = aligned && (idx == IDX_SYNC);
    wire logic mapped = hit_temp | hit_mask | hit_offa | hit_offb | hit_sync;
    wire logic wr = access && PWRITE_I && mapped;
    // Readout is read-only: a write to it is flagged as an error
    wire logic bad = !mapped || (PWRITE_I && hit_temp);
    // Low two byte lanes carry the 16-bit registers
    wire logic [15:0] wmask = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
    wire logic [15:0] wdata = PWDATA_I[15:0];
    wire logic wr_offa = wr && hit_offa;
    // Auto-sync fires on any write to channel A, even strobes all low
    wire logic sync_fire = wr_offa && auto_sync_reg;

    // Zero-wait slave: answers in the access cycle
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access && bad;
    assign PRDATA_O = rdata_reg;

    // Sensor and alarm inputs come from other domains
    always_ff @(posedge CORE_CLK_I) begin
        temp_s1_reg <= TEMP_SENSOR_I;
        temp_s2_reg <= temp_s1_reg;
        alarm_s1_reg <= ALARM_STATUS_I;
        alarm_s2_reg <= alarm_s1_reg;
    end

    // Read mux; reserved bits read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit_temp) begin
            rdata_next[TEMP_LSB +: 8] = temp_s2_reg;
        end else if (hit_mask) begin
            rdata_next[15:0] = mask_reg;
        end else if (hit_offa) begin
            rdata_next[OFF_W-1:0] = offa_reg;
        end else if (hit_offb) begin
            rdata_next[15:13] = fifo_ofs_reg;
            rdata_next[OFF_W-1:0] = offb_reg;
        end else if (hit_sync) begin
            rdata_next[SYNC_AUTO_BIT] = auto_sync_reg;
        end
    end

    // Read data sampled in setup so it stands during the access cycle
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rdata_reg <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            rdata_reg <= rdata_next;
        end
    end

    // Mask register, byte-lane writes
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            mask_reg <= MASK_RST;
        end else if (wr && hit_mask) begin
            mask_reg <= (mask_reg & ~wmask) | (wdata & wmask);
        end
    end

    // Staging registers; upper reserved bits of A are never stored
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            offa_reg <= OFFA_RST[OFF_W-1:0];
            offb_reg <= OFFB_RST[OFF_W-1:0];
            fifo_ofs_reg <= FIFO_OFS_RST;
            auto_sync_reg <= SYNC_RST[SYNC_AUTO_BIT];
        end else begin
            if (wr_offa) begin
                offa_reg <= (offa_reg & ~wmask[OFF_W-1:0])
                    | (wdata[OFF_W-1:0] & wmask[OFF_W-1:0]);
            end
            if (wr && hit_offb) begin
                offb_reg <= (offb_reg & ~wmask[OFF_W-1:0])
                    | (wdata[OFF_W-1:0] & wmask[OFF_W-1:0]);
                if (PSTRB_I[1]) begin
                    fifo_ofs_reg <= wdata[15:13];
                end
            end
            if (wr && hit_sync && PSTRB_I[0]) begin
                auto_sync_reg <= wdata[SYNC_AUTO_BIT];
            end
        end
    end

    // Sync one cycle after the A write loads both lanes together, so the
    // new A value is already staged; a B write alone never reaches here
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            sync_reg <= 1'b0;
            act_a_reg <= OFFA_RST[OFF_W-1:0];
            act_b_reg <= OFFB_RST[OFF_W-1:0];
        end else begin
            sync_reg <= sync_fire;
            if (sync_reg) begin
                act_a_reg <= offa_reg;
                act_b_reg <= offb_reg;
            end
        end
    end

    assign OFFSET_A_O = act_a_reg;
    assign OFFSET_B_O = act_b_reg;
    assign OFFSET_SYNC_O = sync_reg;

    // Status stays outside; masking only gates the combined output.
    // Unused bits are ignored whatever the status says.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            ALARM_O <= 1'b0;
        end else begin
            ALARM_O <= |(alarm_s2_reg & ~mask_reg & MASK_USED);
        end
    end

    // Assertions
    property p_mask_reset;
        @(posedge CORE_CLK_I) $fell(RST_I) |-> mask_reg == MASK_RST;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask reset");

    property p_offa_reset;
        @(posedge CORE_CLK_I) $fell(RST_I) |-> offa_reg == 13'h0000;
    endproperty
    a_offa_reset: assert property (p_offa_reset) else $error("offa reset");

    property p_sync_cause;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            OFFSET_SYNC_O |-> $past(wr_offa) && $past(auto_sync_reg);
    endproperty
    a_sync_cause: assert property (p_sync_cause) else $error("stray sync");

    property p_sync_follows;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            sync_fire |=> OFFSET_SYNC_O ##1 (OFFSET_A_O == offa_reg);
    endproperty
    a_sync_follows: assert property (p_sync_follows) else $error("no sync");

    property p_both_load;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            OFFSET_SYNC_O |=> OFFSET_A_O == $past(offa_reg)
                && OFFSET_B_O == $past(offb_reg);
    endproperty
    a_both_load: assert property (p_both_load) else $error("split load");

    property p_b_hold;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            !OFFSET_SYNC_O |=> $stable(OFFSET_B_O) && $stable(OFFSET_A_O);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("offset moved");

    property p_temp_read;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            access && !PWRITE_I && hit_temp |->
                PRDATA_O[7:0] == 8'h00
                && PRDATA_O[15:8] == $past(temp_s2_reg);
    endproperty
    a_temp_read: assert property (p_temp_read) else $error("temp read");

    property p_temp_ro;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            access && PWRITE_I && hit_temp |-> PSLVERR_O;
    endproperty
    a_temp_ro: assert property (p_temp_ro) else $error("temp written");

    property p_mask_write;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            wr && hit_mask && PSTRB_I == 4'hF |=> mask_reg == $past(wdata);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write");

    property p_alarm_gate;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            (alarm_s2_reg & ~mask_reg & MASK_USED) == 16'h0000 |=> !ALARM_O;
    endproperty
    a_alarm_gate: assert property (p_alarm_gate) else $error("alarm leak");

    property p_offa_top;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            access && !PWRITE_I && hit_offa |-> PRDATA_O[15:13] == 3'h0;
    endproperty
    a_offa_top: assert property (p_offa_top) else $error("offa top");

    // Channel B staging comes out of reset at zero and its upper field at FIFO_OFS_RST
    property p_offb_reset;
        @(posedge CORE_CLK_I) $fell(RST_I) |->
            offb_reg == 13'h0000 && fifo_ofs_reg == FIFO_OFS_RST;
    endproperty
    a_offb_reset: assert property (p_offb_reset) else $error("offb reset");

    // Any unmasked used status bit must reach the combined output
    property p_alarm_raise;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            (alarm_s2_reg & ~mask_reg & MASK_USED) != 16'h0000 |=> ALARM_O;
    endproperty
    a_alarm_raise: assert property (p_alarm_raise) else $error("alarm lost");

    // Unused bit positions never raise the combined alarm
    property p_alarm_unused;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            (alarm_s2_reg & MASK_USED) == 16'h0000 |=> !ALARM_O;
    endproperty
    a_alarm_unused: assert property (p_alarm_unused) else $error("unused");

    // A channel-B write alone must not start a sync
    property p_offb_no_sync;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            wr && hit_offb |=> !OFFSET_SYNC_O;
    endproperty
    a_offb_no_sync: assert property (p_offb_no_sync) else $error("b sync");

    // With auto-sync off an A write only stages the value
    property p_sync_off;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            wr_offa && !auto_sync_reg |=> !OFFSET_SYNC_O;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync while off");

    // Transfers take two cycles, so a sync is always a single pulse
    property p_sync_pulse;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            OFFSET_SYNC_O |=> !OFFSET_SYNC_O;
    endproperty
    a_sync_pulse: assert property (p_sync_pulse) else $error("long sync");

    // Strobes all low leave the mask untouched
    property p_mask_lane;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            wr && hit_mask && PSTRB_I[1:0] == 2'h0 |=> $stable(mask_reg);
    endproperty
    a_mask_lane: assert property (p_mask_lane) else $error("mask lanes");

    // A refused write to the readout has no side effect
    property p_err_no_write;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            access && PWRITE_I && hit_temp |=> $stable(mask_reg)
                && $stable(offa_reg) && $stable(offb_reg);
    endproperty
    a_err_no_write: assert property (p_err_no_write) else $error("ro hit");

    // A full-word write stores the low 13 bits of channel A
    property p_offa_write;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            wr_offa && PSTRB_I[1:0] == 2'h3 |=>
                offa_reg == $past(wdata[OFF_W-1:0]);
    endproperty
    a_offa_write: assert property (p_offa_write) else $error("offa write");

    // A full-word write stores the low 13 bits of channel B
    property p_offb_write;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            wr && hit_offb && PSTRB_I[1:0] == 2'h3 |=>
                offb_reg == $past(wdata[OFF_W-1:0]);
    endproperty
    a_offb_write: assert property (p_offb_write) else $error("offb write");

    // Channel A read returns the value staged at the setup edge
    property p_offa_read;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            access && !PWRITE_I && hit_offa |->
                PRDATA_O[OFF_W-1:0] == $past(offa_reg);
    endproperty
    a_offa_read: assert property (p_offa_read) else $error("offa read");

    // Registers are 16 bits: the upper half of read data is zero
    property p_upper_zero;
        @(posedge CORE_CLK_I) disable iff (RST_I)
            access && !PWRITE_I |-> PRDATA_O[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read");

    // Reset keeps the sync pulse and combined alarm quiet
    property p_reset_quiet;
        @(posedge CORE_CLK_I) RST_I |=> !OFFSET_SYNC_O && !ALARM_O;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset out");

    // Main scenarios seen by the bench
    c_sync: cover property (@(posedge CORE_CLK_I) OFFSET_SYNC_O);
    c_alarm: cover property (@(posedge CORE_CLK_I) ALARM_O);
    c_b_write: cover property (@(posedge CORE_CLK_I) wr && hit_offb);
    c_err: cover property (@(posedge CORE_CLK_I) PSLVERR_O);
    c_temp: cover property (@(posedge CORE_CLK_I) access && hit_temp);

endmodule // amto_regs

// *** tb/alarm_mask_temp_offset_regs_tb.sv ***
// Self-checking bench for the mask, temperature and offset register bank
`timescale 1ns/1ns
module alarm_mask_temp_offset_regs_tb;
    import amto_pkg::*;
    logic clk, rst, psel, pen, pwr, pready, pslverr, sync_o, alarm;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] temp;
    logic [15:0] status, mk;
    logic [OFF_W-1:0] off_a, off_b;
    logic [31:0] sync_cnt = 32'h0;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    amto_regs amto_regs_i (
        .CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .TEMP_SENSOR_I(temp), .ALARM_STATUS_I(status), .OFFSET_A_O(off_a),
        .OFFSET_B_O(off_b), .OFFSET_SYNC_O(sync_o), .ALARM_O(alarm)
    );

    // 50 MHz core clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Count sync pulses and cut a hang short
    always @(posedge clk) begin
        if (sync_o === 1'h1) sync_cnt <= sync_cnt + 32'h1;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("Compares %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits on pready rather than trusting zero wait
    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [15:0] wd, input logic [3:0] st,
        output logic [31:0] rd, output logic err);
        int n = 0;
        psel <= 1'h1;
        pwr <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {16'h0000, wd};
        pstrb <= st;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        err = pslverr;
        // Zero-wait slave: the first access edge must carry pready
        check(n, 32'h1);
        psel <= 1'h0;
        pen <= 1'h0;
        // Idle cycle keeps two transfers from driving psel in one step
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] d,
        input logic [3:0] st, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'h1, idx, d, st, r, e);
        check({31'h0, e}, {31'h0, exp_err});
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp,
        input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'h0, idx, 16'h0000, 4'h0, r, e);
        check({31'h0, e}, {31'h0, exp_err});
        if (!exp_err) check(r, {16'h0000, exp});
    endtask

    // Main sequence
    initial begin
        rst = 1'h1;
        psel = 1'h0;
        pen = 1'h0;
        pwr = 1'h0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        temp = 8'hE7;
        status = 16'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rd_chk(IDX_MASK, MASK_RST, 1'h0);
        rd_chk(IDX_OFFA, OFFA_RST, 1'h0);
        rd_chk(IDX_OFFB, 16'h8000, 1'h0);
        rd_chk(IDX_TEMP, 16'hE700, 1'h0);
        temp <= 8'h19;
        repeat (4) @(posedge clk);
        wr(IDX_TEMP, 16'h1234, 4'h3, 1'h1);
        // Bus clock here is far slower than the readout's minimum period
        rd_chk(IDX_TEMP, 16'h1900, 1'h0);
        rd_chk(8'hFF, 16'h0000, 1'h1);
        // Every alarm starts masked
        status <= 16'hFFFF;
        repeat (5) @(posedge clk);
        check({31'h0, alarm}, 32'h0);
        // Low byte open via one strobe lane, then high byte open
        for (int m = 0; m < 2; m++) begin
            mk = m ? 16'h00FF : 16'hFF00;
            if (m == 0) wr(IDX_MASK, 16'h0000, 4'h1, 1'h0);
            else wr(IDX_MASK, 16'h00FF, 4'h3, 1'h0);
            rd_chk(IDX_MASK, mk, 1'h0);
            for (int b = 0; b < 16; b++) begin
                status <= 16'h0001 << b;
                repeat (5) @(posedge clk);
                check({31'h0, alarm}, {31'h0, MASK_USED[b] & ~mk[b]});
            end
        end
        status <= 16'h0000;
        // Auto-sync off: back-to-back writes leave the datapath alone
        wr(IDX_OFFB, 16'h0ABC, 4'h3, 1'h0);
        wr(IDX_OFFA, 16'h0123, 4'h3, 1'h0);
        repeat (4) @(posedge clk);
        check(sync_cnt, 32'h0);
        check({19'h0, off_a}, 32'h0);
        wr(IDX_SYNC, 16'h0001, 4'h3, 1'h0);
        wr(IDX_OFFB, 16'h1555, 4'h3, 1'h0);
        repeat (4) @(posedge clk);
        check({19'h0, off_b}, 32'h0);
        wr(IDX_OFFA, 16'hFFFF, 4'h3, 1'h0);
        repeat (4) @(posedge clk);
        check(sync_cnt, 32'h1);
        check({19'h0, off_a}, 32'h1FFF);
        check({19'h0, off_b}, 32'h1555);
        rd_chk(IDX_OFFA, 16'h1FFF, 1'h0);
        rd_chk(IDX_OFFB, 16'h1555, 1'h0);
        complete_run();
    end
endmodule // alarm_mask_temp_offset_regs_tb
